// File: cmt_guard_map.svh
// Purpose: Offsets, field positions, reset values and timing figures of the guard
// Assumes: Included by its bare name wherever a figure is needed
// Notes:   Definitions only
`ifndef CMT_GUARD_MAP_SVH
`define CMT_GUARD_MAP_SVH

`define CMT_ADDR_COMPARE       8'h1f
`define CMT_ADDR_CONDITION     8'h20
`define CMT_ADDR_THRESHOLD     8'h24
`define CMT_ADDR_ZERO          8'h00

`define CMT_BIT_TRIGGER        7
`define CMT_BIT_SCRUB          6
`define CMT_IDX_TRIGGER        1
`define CMT_IDX_SCRUB          0
`define CMT_RES_ZERO           6'h00

`define CMT_FLAGS_RESET        2'h0
`define CMT_THRESHOLD_RESET    8'h00
`define CMT_CONFIG_RESET       8'h00
`define CMT_BYTE_ZERO          8'h00
`define CMT_STEPS_ZERO         8'h00
`define CMT_STEPS_ONE          8'h01
`define CMT_PRESCALE_ZERO      16'h0000
`define CMT_PRESCALE_ONE       16'h0001
`define CMT_PRESCALE_LIMIT     65536

`define CMT_SYM_IDLE           2'h0
`define CMT_SYM_INVALID        2'h1
`define CMT_SYM_SCRUB          2'h2

`define CMT_SCRUB_STEP_US      40.96
`define CMT_CLOCK_MHZ          250.0

`define AUX_CNT_ZERO           4'h0
`define AUX_CNT_ONE            4'h1
`define AUX_BIT_FAST           2
`define AUX_BIT_SLOW           3

`endif

// File: cmt_guard_pkg.sv
// Purpose: Types shared by the condition guard and the aux clock divider
// Assumes: Figures live in cmt_guard_map.svh
// Notes:   State of each module is one packed struct
package cmt_guard_pkg;

    typedef enum logic [3:0] {
        SEQ_IDLE    = 4'h1,
        SEQ_INV_A   = 4'h2,
        SEQ_INV_B   = 4'h4,
        SEQ_SCRUB   = 4'h8
    } scrub_seq_t;

    typedef struct packed {
        logic [1:0]  flags;
        logic [1:0]  compare;
        logic [7:0]  threshold;
        logic [7:0]  rdata;
        logic        inhibit;
        logic [7:0]  active_config;
        logic [7:0]  steps_left;
        logic [15:0] prescale;
        logic        pair_phase;
        scrub_seq_t  seq;
        logic [1:0]  symbol;
        logic        scrub;
    } guard_state_t;

    typedef struct packed {
        logic [3:0]  cnt;
        logic        sel;
        logic        clk_out;
    } aux_state_t;

endpackage

// File: aux_clock_if.sv
// Purpose: Carries the aux clock select and its divided output
// Assumes: Both ends on the core clock
// Notes:   None
`timescale 1ns/10ps
`default_nettype none

interface aux_clock_if;
    logic freq_select;
    logic clk_out;

    modport master (output freq_select, input clk_out);
    modport divider (input freq_select, output clk_out);
endinterface

`default_nettype wire

// File: aux_clock_divider.sv
// Purpose: Divides the core clock to the aux clock, select 0 slow, 1 fast
// Assumes: Core clock 250 MHz, so divide by 16 or by 8
// Notes:   Select is adopted only when the counter wraps, both phases low
`timescale 1ns/10ps
`default_nettype none
`include "cmt_guard_map.svh"

module aux_clock_divider (
    input  wire logic      clock,
    input  wire logic      reset_n,
    aux_clock_if.divider   aux
);

    cmt_guard_pkg::aux_state_t s_reg;
    cmt_guard_pkg::aux_state_t s_next;

    always_comb begin
        s_next     = s_reg;
        s_next.cnt = s_reg.cnt + `AUX_CNT_ONE;
        // Change rate only at the wrap, where both dividers sit low
        if (s_reg.cnt == `AUX_CNT_ZERO) begin
            s_next.sel = aux.freq_select;
        end
        s_next.clk_out = s_reg.sel ? s_next.cnt[`AUX_BIT_FAST] : s_next.cnt[`AUX_BIT_SLOW];
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign aux.clk_out = s_reg.clk_out;

endmodule

`default_nettype wire

// File: cmt_condition_write_guard.sv
// Purpose: Condition flags with read-before-write guard, scrub sequencer, aux clock
// Assumes: Control bus strobes and trigger pulse come from core-clock logic
// Notes:   One transmit symbol per clock; read data valid the cycle after cbus_rd
`timescale 1ns/10ps
`default_nettype none
`include "cmt_guard_map.svh"

module cmt_condition_write_guard #(
    parameter int STEP_CYCLES = int'(`CMT_SCRUB_STEP_US * `CMT_CLOCK_MHZ)
) (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       cbus_rd,
    input  wire logic       cbus_wr,
    input  wire logic [7:0] cbus_addr,
    input  wire logic [7:0] cbus_wdata,
    output logic      [7:0] cbus_rdata,
    input  wire logic       trigger_event,
    input  wire logic       scrub_on_trigger_enable,
    input  wire logic [7:0] trigger_transition_config,
    input  wire logic       aux_clock_freq_select,
    output logic      [7:0] active_config,
    output logic      [1:0] tx_symbol,
    output logic            scrubbing,
    output logic      [1:0] cmt_condition_flags,
    output logic            cond_write_inhibit_flag,
    output logic            aux_clock_output
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    if (STEP_CYCLES < 1 || STEP_CYCLES > `CMT_PRESCALE_LIMIT) begin : g_bad_step
        $error("STEP_CYCLES out of range");
    end

    localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Aux clock

    aux_clock_if aux ();

    assign aux.freq_select = aux_clock_freq_select;

    aux_clock_divider u_aux (
        .clock   (clock),
        .reset_n (reset_n),
        .aux     (aux.divider)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // State

    cmt_guard_pkg::guard_state_t s_reg;
    cmt_guard_pkg::guard_state_t s_next;

    logic        rd_cond;
    logic        wr_cond;
    logic        wr_cmp;
    logic        wr_thr;
    logic        start;
    logic        expire;
    logic [1:0]  wr_flags;

    assign rd_cond = cbus_rd && (cbus_addr == `CMT_ADDR_CONDITION);
    assign wr_cond = cbus_wr && (cbus_addr == `CMT_ADDR_CONDITION);
    assign wr_cmp  = cbus_wr && (cbus_addr == `CMT_ADDR_COMPARE);
    assign wr_thr  = cbus_wr && (cbus_addr == `CMT_ADDR_THRESHOLD);
    assign wr_flags = {cbus_wdata[`CMT_BIT_TRIGGER], cbus_wdata[`CMT_BIT_SCRUB]};
    assign start   = trigger_event && scrub_on_trigger_enable;
    assign expire  = (s_reg.seq == cmt_guard_pkg::SEQ_SCRUB)
                     && (s_reg.steps_left == `CMT_STEPS_ZERO)
                     && (s_reg.prescale == `CMT_PRESCALE_ZERO)
                     && s_reg.pair_phase;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_next         = s_reg;
        s_next.inhibit = 1'b0;

        // Register reads
        if (cbus_rd) begin
            case (cbus_addr)
                `CMT_ADDR_COMPARE: begin
                    s_next.rdata = {s_reg.compare, `CMT_RES_ZERO};
                end
                `CMT_ADDR_CONDITION: begin
                    s_next.rdata = {s_reg.flags, `CMT_RES_ZERO};
                end
                `CMT_ADDR_THRESHOLD: begin
                    s_next.rdata = s_reg.threshold;
                end
                default: begin
                    s_next.rdata = `CMT_BYTE_ZERO;
                end
            endcase
        end

        // Compare shadow: loaded by a condition read, else by a direct write
        if (rd_cond) begin
            s_next.compare = s_reg.flags;
        end else if (wr_cmp) begin
            s_next.compare = {cbus_wdata[`CMT_BIT_TRIGGER], cbus_wdata[`CMT_BIT_SCRUB]};
        end

        // Guarded write of the condition flags
        if (wr_cond) begin
            for (int i = 0; i < 2; i++) begin
                if (s_reg.flags[i] == s_reg.compare[i]) begin
                    s_next.flags[i] = wr_flags[i];
                end else begin
                    s_next.inhibit = 1'b1;
                end
            end
        end

        if (wr_thr) begin
            s_next.threshold = cbus_wdata;
        end

        // Scrub sequencer
        case (s_reg.seq)
            cmt_guard_pkg::SEQ_IDLE: begin
                s_next.symbol = `CMT_SYM_IDLE;
                if (start) begin
                    s_next.seq    = cmt_guard_pkg::SEQ_INV_A;
                    s_next.symbol = `CMT_SYM_INVALID;
                end
            end
            cmt_guard_pkg::SEQ_INV_A: begin
                s_next.seq    = cmt_guard_pkg::SEQ_INV_B;
                s_next.symbol = `CMT_SYM_INVALID;
            end
            cmt_guard_pkg::SEQ_INV_B: begin
                s_next.seq        = cmt_guard_pkg::SEQ_SCRUB;
                s_next.symbol     = `CMT_SYM_SCRUB;
                s_next.steps_left = s_reg.threshold;
                s_next.prescale   = STEP_LAST;
                s_next.pair_phase = 1'b0;
            end
            cmt_guard_pkg::SEQ_SCRUB: begin
                s_next.pair_phase = !s_reg.pair_phase;
                if (s_reg.prescale != `CMT_PRESCALE_ZERO) begin
                    s_next.prescale = s_reg.prescale - `CMT_PRESCALE_ONE;
                end else if (s_reg.steps_left != `CMT_STEPS_ZERO) begin
                    s_next.prescale   = STEP_LAST;
                    s_next.steps_left = s_reg.steps_left - `CMT_STEPS_ONE;
                end
                if (expire) begin
                    s_next.seq    = cmt_guard_pkg::SEQ_IDLE;
                    s_next.symbol = `CMT_SYM_IDLE;
                end else begin
                    s_next.symbol = `CMT_SYM_SCRUB;
                end
            end
            default: begin
                s_next.seq    = cmt_guard_pkg::SEQ_IDLE;
                s_next.symbol = `CMT_SYM_IDLE;
            end
        endcase

        // Enabled trigger loads the transition configuration
        if (start) begin
            s_next.active_config = trigger_transition_config;
        end

        // Hardware sets win over a host clear in the same cycle
        if (trigger_event) begin
            s_next.flags[`CMT_IDX_TRIGGER] = 1'b1;
        end
        if (expire) begin
            s_next.flags[`CMT_IDX_SCRUB] = 1'b1;
        end

        // Busy flag is registered so the output leaves a flip-flop
        s_next.scrub = (s_next.seq != cmt_guard_pkg::SEQ_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_reg.flags         <= `CMT_FLAGS_RESET;
            s_reg.compare       <= `CMT_FLAGS_RESET;
            s_reg.threshold     <= `CMT_THRESHOLD_RESET;
            s_reg.rdata         <= `CMT_BYTE_ZERO;
            s_reg.inhibit       <= 1'b0;
            s_reg.active_config <= `CMT_CONFIG_RESET;
            s_reg.steps_left    <= `CMT_STEPS_ZERO;
            s_reg.prescale      <= `CMT_PRESCALE_ZERO;
            s_reg.pair_phase    <= 1'b0;
            s_reg.seq           <= cmt_guard_pkg::SEQ_IDLE;
            s_reg.symbol        <= `CMT_SYM_IDLE;
            s_reg.scrub         <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign cbus_rdata              = s_reg.rdata;
    assign active_config           = s_reg.active_config;
    assign tx_symbol               = s_reg.symbol;
    assign scrubbing               = s_reg.scrub;
    assign cmt_condition_flags     = s_reg.flags;
    assign cond_write_inhibit_flag = s_reg.inhibit;
    assign aux_clock_output        = aux.clk_out;

endmodule

`default_nettype wire

// File: cmt_guard_checker_assertions.sv
// Purpose: Port assertions for the condition write guard
// Assumes: Bound to every instance of the guard
// Notes:   The compare shadow is mirrored here from bus traffic
`timescale 1ns/10ps
`default_nettype none

module cmt_guard_checker #(
    parameter int STEP_CYCLES = 4
) (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       cbus_rd,
    input wire logic       cbus_wr,
    input wire logic [7:0] cbus_addr,
    input wire logic [7:0] cbus_wdata,
    input wire logic [7:0] cbus_rdata,
    input wire logic       trigger_event,
    input wire logic       scrub_on_trigger_enable,
    input wire logic [7:0] trigger_transition_config,
    input wire logic       aux_clock_freq_select,
    input wire logic [7:0] active_config,
    input wire logic [1:0] tx_symbol,
    input wire logic       scrubbing,
    input wire logic [1:0] cmt_condition_flags,
    input wire logic       cond_write_inhibit_flag,
    input wire logic       aux_clock_output
);
    logic [1:0] shadow;
    logic       mismatch;
    logic       hi_diff;
    logic       wr_cond;
    assign mismatch = cmt_condition_flags != shadow;
    assign hi_diff = cmt_condition_flags[1] != shadow[1];
    assign wr_cond = cbus_wr && cbus_addr == 8'h20;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shadow <= 2'h0;
        end else if (cbus_rd && cbus_addr == 8'h20) begin
            shadow <= cmt_condition_flags;
        end else if (cbus_wr && cbus_addr == 8'h1f) begin
            shadow <= cbus_wdata[7:6];
        end
    end
    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////
    a_read_copy: assert property (cbus_rd && cbus_addr == 8'h20 |=>
        cbus_rdata == {$past(cmt_condition_flags), 6'h00}) else $error("bad read data");
    a_inhibit_on_diff: assert property (wr_cond |=>
        cond_write_inhibit_flag == $past(mismatch)) else $error("bad inhibit");
    a_guard_hold: assert property (wr_cond && hi_diff && !trigger_event |=>
        $stable(cmt_condition_flags[1])) else $error("guarded bit changed");
    a_trigger_sets: assert property (trigger_event |=>
        cmt_condition_flags[1]) else $error("trigger flag not set");
    a_config_load: assert property (trigger_event && scrub_on_trigger_enable |=>
        active_config == $past(trigger_transition_config)) else $error("config not loaded");
    a_invalid_pair: assert property (trigger_event && scrub_on_trigger_enable && !scrubbing |=>
        tx_symbol == 2'h1 ##1 tx_symbol == 2'h1 ##1 tx_symbol == 2'h2) else $error("bad prefix");
    a_busy_symbol: assert property (scrubbing |->
        tx_symbol != 2'h0) else $error("idle symbol while scrubbing");
    a_idle_stays: assert property (!scrubbing && !(trigger_event && scrub_on_trigger_enable) |=>
        !scrubbing && tx_symbol == 2'h0) else $error("scrub without trigger");
    a_expiry_flag: assert property ($fell(scrubbing) |->
        cmt_condition_flags[0] && tx_symbol == 2'h0) else $error("expiry flag missing");
    a_aux_high: assert property ($rose(aux_clock_output) |->
        aux_clock_output [*4]) else $error("short aux high");
    a_aux_low: assert property ($fell(aux_clock_output) |->
        !aux_clock_output [*4]) else $error("short aux low");
endmodule

bind cmt_condition_write_guard cmt_guard_checker #(.STEP_CYCLES(STEP_CYCLES)) chk (
    .clock(clock), .reset_n(reset_n), .cbus_rd(cbus_rd), .cbus_wr(cbus_wr),
    .cbus_addr(cbus_addr), .cbus_wdata(cbus_wdata), .cbus_rdata(cbus_rdata),
    .trigger_event(trigger_event), .scrub_on_trigger_enable(scrub_on_trigger_enable),
    .trigger_transition_config(trigger_transition_config),
    .aux_clock_freq_select(aux_clock_freq_select), .active_config(active_config),
    .tx_symbol(tx_symbol), .scrubbing(scrubbing), .cmt_condition_flags(cmt_condition_flags),
    .cond_write_inhibit_flag(cond_write_inhibit_flag), .aux_clock_output(aux_clock_output)
);

`default_nettype wire

// File: cbus_host_model.sv
// Purpose: Host on the control bus, one strobe per access
// Assumes: Calls start and end at a falling edge
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/10ps
`default_nettype none

module cbus_host_model (
    input  wire logic       clock,
    output logic            cbus_rd,
    output logic            cbus_wr,
    output logic      [7:0] cbus_addr,
    output logic      [7:0] cbus_wdata,
    input  wire logic [7:0] cbus_rdata
);
    initial begin
        cbus_rd = 1'b0;
        cbus_wr = 1'b0;
        cbus_addr = 8'h00;
        cbus_wdata = 8'h00;
    end
    task automatic access(input logic rd, input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        cbus_rd = rd;
        cbus_wr = wr;
        cbus_addr = a;
        cbus_wdata = d;
        @(negedge clock);
        q = cbus_rdata;
    endtask
    task automatic idle;
        logic [7:0] q;
        access(1'b0, 1'b0, ~cbus_addr, ~cbus_wdata, q);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
        access(1'b1, 1'b0, a, ~cbus_wdata, q);
        idle();
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(1'b0, 1'b1, a, d, q);
        idle();
    endtask
    // Read the condition flags, then write them on the next edge
    task automatic guarded_write(input logic [7:0] d);
        logic [7:0] q;
        access(1'b1, 1'b0, 8'h20, ~cbus_wdata, q);
        access(1'b0, 1'b1, 8'h20, d, q);
        idle();
    endtask
endmodule

`default_nettype wire

// File: tb_cmt_condition_write_guard.sv
// Purpose: Self-checking bench for the condition write guard
// Assumes: Scrub step shortened to 4 clocks
// Notes:   Inputs change at falling edges
`timescale 1ns/10ps
`default_nettype none

module tb_cmt_condition_write_guard;
    logic       clock = 1'b0;
    logic       reset_n = 1'b0;
    logic       cbus_rd, cbus_wr, trigger_event = 1'b0, scrub_on_trigger_enable = 1'b0;
    logic       aux_clock_freq_select = 1'b0, scrubbing, cond_write_inhibit_flag, aux_clock_output;
    logic [7:0] cbus_addr, cbus_wdata, cbus_rdata, active_config, q;
    logic [7:0] trigger_transition_config = 8'h00;
    logic [1:0] tx_symbol, cmt_condition_flags;
    int         error_cnt = 0, num_checks = 0, inh_cnt = 0, i, n;

    always #2 clock = ~clock;
    always @(negedge clock) begin
        if (cond_write_inhibit_flag === 1'b1) inh_cnt++;
    end
    cbus_host_model host (.clock(clock), .cbus_rd(cbus_rd), .cbus_wr(cbus_wr),
        .cbus_addr(cbus_addr), .cbus_wdata(cbus_wdata), .cbus_rdata(cbus_rdata));
    cmt_condition_write_guard #(.STEP_CYCLES(4)) uut (.clock(clock), .reset_n(reset_n),
        .cbus_rd(cbus_rd), .cbus_wr(cbus_wr), .cbus_addr(cbus_addr), .cbus_wdata(cbus_wdata),
        .cbus_rdata(cbus_rdata), .trigger_event(trigger_event),
        .scrub_on_trigger_enable(scrub_on_trigger_enable),
        .trigger_transition_config(trigger_transition_config),
        .aux_clock_freq_select(aux_clock_freq_select), .active_config(active_config),
        .tx_symbol(tx_symbol), .scrubbing(scrubbing), .cmt_condition_flags(cmt_condition_flags),
        .cond_write_inhibit_flag(cond_write_inhibit_flag), .aux_clock_output(aux_clock_output));
    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse_trigger(input logic en);
        scrub_on_trigger_enable = en;
        trigger_event = 1'b1;
        @(negedge clock);
        trigger_event = 1'b0;
    endtask
    function automatic logic [7:0] fl();
        return {6'h00, cmt_condition_flags};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_map;
        logic [7:0] v [2] = '{8'hbf, 8'h40};
        check(fl(), 8'h00);
        foreach (v[k]) begin
            host.wr_reg(8'h1f, v[k]);
            host.rd_reg(8'h1f, q);
            check(q, v[k] & 8'hc0);
        end
        host.rd_reg(8'h30, q);
        check(q, 8'h00);
    endtask
    task automatic t_scrub;
        host.wr_reg(8'h24, 8'h01);
        host.rd_reg(8'h24, q);
        check(q, 8'h01);
        trigger_transition_config = 8'h5a;
        pulse_trigger(1'b1);
        check({6'h00, tx_symbol}, 8'h01);
        check(active_config, 8'h5a);
        check(fl(), 8'h02);
        @(negedge clock);
        check({6'h00, tx_symbol}, 8'h01);
        n = 0;
        for (i = 0; i < 200 && scrubbing === 1'b1; i++) begin
            @(negedge clock);
            if (tx_symbol === 2'h2) n++;
        end
        if (i == 200) begin
            error_cnt++;
            print_verdict();
        end
        check({7'h00, n[0]}, 8'h00);
        check({7'h00, n > 0}, 8'h01);
        // Threshold 1 with a 4-clock step spans two steps of scrub symbols
        check(8'(n), 8'h08);
        check(fl(), 8'h03);
        trigger_transition_config = 8'ha5;
        pulse_trigger(1'b0);
        check({7'h00, scrubbing}, 8'h00);
        check(active_config, 8'h5a);
    endtask
    task automatic t_guard;
        host.guarded_write(8'h00);
        check(fl(), 8'h00);
        host.wr_reg(8'h20, 8'hc0);
        check(fl(), 8'h00);
        check(8'(inh_cnt), 8'h01);
        host.rd_reg(8'h20, q);
        check(q, 8'h00);
        pulse_trigger(1'b0);
        host.wr_reg(8'h20, 8'h00);
        check(fl(), 8'h02);
        check(8'(inh_cnt), 8'h02);
        host.wr_reg(8'h1f, 8'h80);
        host.wr_reg(8'h20, 8'h00);
        check(fl(), 8'h00);
        check(8'(inh_cnt), 8'h02);
    endtask
    task automatic t_aux;
        logic last;
        n = 0;
        last = aux_clock_output;
        for (i = 0; i < 160; i++) begin
            if (i == 70) aux_clock_freq_select = 1'b1;
            @(negedge clock);
            n++;
            if (aux_clock_output !== last) begin
                if (i > 20) check({7'h00, n == 4 || n == 8}, 8'h01);
                if (i > 20 && i < 70) check(8'(n), 8'h08);
                if (i > 100) check(8'(n), 8'h04);
                n = 0;
                last = aux_clock_output;
            end
        end
    endtask
    initial begin
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
        t_reset_and_map();
        t_scrub();
        t_guard();
        t_aux();
        print_verdict();
    end
endmodule

`default_nettype wire
